// ### rtc_trim_backup_regs.svh
// Register map, field positions, reset values and prescaler counts
`ifndef RTC_TRIM_BACKUP_REGS_SVH
`define RTC_TRIM_BACKUP_REGS_SVH

// Register offsets
`define STATUS_ADDR 8'h03
`define CONTROL_ADDR 8'h07
`define OSC_TRIM_ADDR 8'h08
`define ALARM_CFG_ADDR 8'h0D
`define PD_STAMP_ADDR 8'h18
`define PU_STAMP_ADDR 8'h1C

// Reset values
`define CONTROL_RESET 8'h80
`define OSC_TRIM_RESET 8'h00
`define STATUS_RESET 8'h00
`define ALARM_CFG_RESET 8'h00

// Field positions
`define STAT_POWER_LOSS_BIT 4
`define STAT_BACKUP_EN_BIT 3
`define ALM_POL_BIT 7
`define ALM_ZERO_FLAG_BIT 3
`define ALM_ONE_FLAG_BIT 2

// Unimplemented time-stamp bits read as zero
`define STAMP_MASK 32'hFF3F7F7F

// Oscillator cycles per 128 Hz segment, minus one
`define SEG_LAST 9'h0FF
// Last segment index inside one second
`define SEG_IDX_LAST 7'h7F
// Last second inside one minute
`define SEC_LAST 6'h3B

`endif

// ### rtc_trim_backup_pkg.sv
// Types shared by the trim, output and backup logic
package rtc_trim_backup_pkg;

   typedef struct packed {
      logic out_level;
      logic square_wave_enable;
      logic alarm_one_enable;
      logic alarm_zero_enable;
      logic external_clock_select;
      logic coarse_trim_enable;
      logic [1:0] clock_output_select;
   } control_t;

   typedef struct packed {
      logic add_cycles;
      logic [6:0] trim_step_count;
   } trim_t;

   typedef struct packed {
      logic [7:0] month;
      logic [7:0] date;
      logic [7:0] hour;
      logic [7:0] minute;
   } stamp_t;

   typedef enum logic [1:0] {
      PIN_GPO,
      PIN_ALARM,
      PIN_SQW
   } pin_mode_t;

endpackage : rtc_trim_backup_pkg

// ### rtc_trim_prescaler.sv
// Trimmed 32.768 kHz prescaler: seconds tick and divided clock outputs
`timescale 1ns/100ps
`include "rtc_trim_backup_regs.svh"

module rtc_trim_prescaler (
   // Clock and reset
   input wire logic clk_i,
   input wire logic resetn_i,
   // Oscillator edge and trim setting
   input wire logic osc_tick_i,
   input wire logic coarse_i,
   input wire rtc_trim_backup_pkg::trim_t trim_i,
   // Timebase outputs
   output logic sec_tick_o,
   output logic sqw_1hz_o,
   output logic sqw_4khz_o,
   output logic sqw_8khz_o,
   output logic sqw_64hz_o
);

   logic [8:0] seg_cnt_reg;
   logic [6:0] seg_idx_reg;
   logic [5:0] sec_reg;
   logic hz64_reg;
   logic sec_tick_reg;
   logic adjust_now;
   logic [8:0] adj;
   logic [8:0] seg_end;
   logic seg_wrap;

   // No notion of backup here: trimming never stops
   assign adjust_now = (trim_i.trim_step_count != 7'h00) &&
      (coarse_i || (sec_reg == `SEC_LAST &&
      seg_idx_reg == `SEG_IDX_LAST));
   assign adj = {1'b0, trim_i.trim_step_count, 1'b0};
   // Adding cycles shortens the period, subtracting lengthens it
   assign seg_end = !adjust_now ? `SEG_LAST :
      trim_i.add_cycles ? `SEG_LAST - adj : `SEG_LAST + adj;
   // Compare with >= so a trim change mid-segment cannot overrun
   assign seg_wrap = osc_tick_i && (seg_cnt_reg >= seg_end);

   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         seg_cnt_reg <= 9'h000;
      end else if (seg_wrap) begin
         seg_cnt_reg <= 9'h000;
      end else if (osc_tick_i) begin
         seg_cnt_reg <= seg_cnt_reg + 9'h001;
      end
   end

   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         seg_idx_reg <= 7'h00;
         sec_reg <= 6'h00;
         hz64_reg <= 1'b0;
      end else if (seg_wrap) begin
         seg_idx_reg <= seg_idx_reg + 7'h01;
         hz64_reg <= !hz64_reg;
         if (seg_idx_reg == `SEG_IDX_LAST) begin
            sec_reg <= (sec_reg == `SEC_LAST) ? 6'h00 : sec_reg + 6'h01;
         end
      end
   end

   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         sec_tick_reg <= 1'b0;
      end else begin
         sec_tick_reg <= seg_wrap && (seg_idx_reg == `SEG_IDX_LAST);
      end
   end

   assign sec_tick_o = sec_tick_reg;
   assign sqw_1hz_o = !seg_idx_reg[6];
   assign sqw_8khz_o = seg_cnt_reg[1];
   assign sqw_4khz_o = seg_cnt_reg[2];
   assign sqw_64hz_o = hz64_reg;

   chk_untrimmed_wrap: assert property (
      @(posedge clk_i) disable iff (!resetn_i)
      (osc_tick_i && trim_i.trim_step_count == 7'h00 &&
       seg_cnt_reg == `SEG_LAST) |=> (seg_cnt_reg == 9'h000))
      else $error("segment did not wrap at 256 cycles without trim");

   chk_fine_plain_seg: assert property (
      @(posedge clk_i) disable iff (!resetn_i)
      (osc_tick_i && !coarse_i && seg_cnt_reg == `SEG_LAST &&
       !(sec_reg == `SEC_LAST && seg_idx_reg == `SEG_IDX_LAST))
      |=> (seg_cnt_reg == 9'h000))
      else $error("fine trim touched a segment other than the last");

endmodule : rtc_trim_prescaler

// ### rtc_trim_backup_output_ctrl.sv
// Digital trim, multi-function pin output and backup time-stamp logic
//
// Design decision made here: the address-and-strobe port.
`timescale 1ns/100ps
`include "rtc_trim_backup_regs.svh"

module rtc_trim_backup_output_ctrl (
   // Clock and reset
   input wire logic clk_i,
   input wire logic resetn_i,
   // Register port
   input wire logic [7:0] addr_i,
   input wire logic [7:0] wdata_i,
   input wire logic wr_i,
   input wire logic rd_i,
   output logic [7:0] rdata_o,
   output logic bus_refused_o,
   // Oscillator and supply
   input wire logic osc_clk_i,
   input wire logic vcc_low_i,
   // Timekeeping side
   input wire rtc_trim_backup_pkg::stamp_t time_now_i,
   input wire logic alarm_zero_flag_i,
   input wire logic alarm_one_flag_i,
   output logic sec_tick_o,
   output logic on_backup_o,
   output logic external_clock_select_o,
   // Multi-function pin, open drain
   output logic multi_function_pin_o,
   output logic multi_function_pin_oe_o
);

   rtc_trim_backup_pkg::control_t ctl_reg;
   rtc_trim_backup_pkg::trim_t trim_reg;
   rtc_trim_backup_pkg::stamp_t pd_reg;
   rtc_trim_backup_pkg::stamp_t pu_reg;
   rtc_trim_backup_pkg::stamp_t time_masked;
   rtc_trim_backup_pkg::pin_mode_t mode;
   logic backup_input_enable_reg;
   logic power_loss_flag_reg;
   logic armed_reg;
   logic on_backup_reg;
   logic on_backup;
   logic down_evt;
   logic up_evt;
   logic osc_prev_reg;
   logic osc_tick;
   logic alarm_output_polarity_reg;
   logic [7:0] rdata_reg;
   logic [7:0] rdata_next;
   logic pin_oe_reg;
   logic pin_level;
   logic wr_ok;
   logic rd_ok;
   logic flag_clear_wr;
   logic gpo_level;
   logic hz64;
   logic hz1;
   logic khz4;
   logic khz8;

   // Byte i of a stamp, minutes first
   function automatic logic [7:0] get_byte(
      input rtc_trim_backup_pkg::stamp_t s,
      input logic [1:0] idx
   );
      logic [31:0] w;
      w = s;
      get_byte = w[{idx, 3'b000} +: 8];
   endfunction : get_byte

   // Replace byte i, keeping unimplemented bits at zero
   function automatic rtc_trim_backup_pkg::stamp_t put_byte(
      input rtc_trim_backup_pkg::stamp_t s,
      input logic [1:0] idx,
      input logic [7:0] b
   );
      logic [31:0] w;
      w = s;
      w[{idx, 3'b000} +: 8] = b;
      put_byte = w & `STAMP_MASK;
   endfunction : put_byte

   function automatic logic in_stamp(
      input logic [7:0] a,
      input logic [7:0] base
   );
      in_stamp = (a[7:2] == base[7:2]);
   endfunction : in_stamp

   // Supply switchover and bus gating
   assign on_backup = vcc_low_i && backup_input_enable_reg;
   assign down_evt = on_backup && !on_backup_reg;
   assign up_evt = !on_backup && on_backup_reg;
   // Access is refused on backup; master gets zero data and a flag
   assign wr_ok = wr_i && !on_backup;
   assign rd_ok = rd_i && !on_backup;
   assign bus_refused_o = (wr_i || rd_i) && on_backup;
   assign flag_clear_wr = wr_ok && addr_i == `STATUS_ADDR &&
      !wdata_i[`STAT_POWER_LOSS_BIT];
   assign time_masked = time_now_i & `STAMP_MASK;

   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         on_backup_reg <= 1'b0;
      end else begin
         on_backup_reg <= on_backup;
      end
   end

   assign on_backup_o = on_backup_reg;

   // Oscillator edge detect; input is synchronous to clk_i
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         // High so a pin already high gives no false edge
         osc_prev_reg <= 1'b1;
      end else begin
         osc_prev_reg <= osc_clk_i;
      end
   end

   assign osc_tick = osc_clk_i && !osc_prev_reg;

   // Control register, kept through backup
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         ctl_reg <= `CONTROL_RESET;
      end else if (wr_ok && addr_i == `CONTROL_ADDR) begin
         ctl_reg <= wdata_i;
      end
   end

   assign external_clock_select_o = ctl_reg.external_clock_select;
   assign gpo_level = ctl_reg.out_level;

   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         trim_reg <= `OSC_TRIM_RESET;
      end else if (wr_ok && addr_i == `OSC_TRIM_ADDR) begin
         trim_reg <= wdata_i;
      end
   end

   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         alarm_output_polarity_reg <= 1'b0;
      end else if (wr_ok && addr_i == `ALARM_CFG_ADDR) begin
         alarm_output_polarity_reg <= wdata_i[`ALM_POL_BIT];
      end
   end

   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         backup_input_enable_reg <= 1'b0;
      end else if (wr_ok && addr_i == `STATUS_ADDR) begin
         backup_input_enable_reg <= wdata_i[`STAT_BACKUP_EN_BIT];
      end
   end

   // Power-loss flag: hardware set wins over a software clear
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         power_loss_flag_reg <= 1'b0;
      end else if (down_evt && !power_loss_flag_reg) begin
         power_loss_flag_reg <= 1'b1;
      end else if (flag_clear_wr) begin
         power_loss_flag_reg <= 1'b0;
      end
   end

   // Up stamp is only taken for an outage whose down stamp was taken
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         armed_reg <= 1'b0;
      end else if (down_evt) begin
         armed_reg <= !power_loss_flag_reg;
      end else if (up_evt) begin
         armed_reg <= 1'b0;
      end
   end

   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         pd_reg <= '0;
      end else if (down_evt && !power_loss_flag_reg) begin
         pd_reg <= time_masked;
      end else if (flag_clear_wr) begin
         pd_reg <= '0;
      end else if (wr_ok && in_stamp(addr_i, `PD_STAMP_ADDR)) begin
         pd_reg <= put_byte(pd_reg, addr_i[1:0], wdata_i);
      end
   end

   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         pu_reg <= '0;
      end else if (up_evt && armed_reg) begin
         pu_reg <= time_masked;
      end else if (flag_clear_wr) begin
         pu_reg <= '0;
      end else if (wr_ok && in_stamp(addr_i, `PU_STAMP_ADDR)) begin
         pu_reg <= put_byte(pu_reg, addr_i[1:0], wdata_i);
      end
   end

   // Read path: data one cycle after the strobe, zero when refused
   always_comb begin
      rdata_next = 8'h00;
      if (rd_ok) begin
         if (addr_i == `CONTROL_ADDR) begin
            rdata_next = ctl_reg;
         end else if (addr_i == `OSC_TRIM_ADDR) begin
            rdata_next = trim_reg;
         end else if (addr_i == `STATUS_ADDR) begin
            rdata_next[`STAT_POWER_LOSS_BIT] = power_loss_flag_reg;
            rdata_next[`STAT_BACKUP_EN_BIT] = backup_input_enable_reg;
         end else if (addr_i == `ALARM_CFG_ADDR) begin
            rdata_next[`ALM_POL_BIT] = alarm_output_polarity_reg;
            rdata_next[`ALM_ZERO_FLAG_BIT] = alarm_zero_flag_i;
            rdata_next[`ALM_ONE_FLAG_BIT] = alarm_one_flag_i;
         end else if (in_stamp(addr_i, `PD_STAMP_ADDR)) begin
            rdata_next = get_byte(pd_reg, addr_i[1:0]);
         end else if (in_stamp(addr_i, `PU_STAMP_ADDR)) begin
            rdata_next = get_byte(pu_reg, addr_i[1:0]);
         end
      end
   end

   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         rdata_reg <= 8'h00;
      end else begin
         rdata_reg <= rdata_next;
      end
   end

   assign rdata_o = rdata_reg;

   rtc_trim_prescaler u_prescaler (
      .clk_i(clk_i),
      .resetn_i(resetn_i),
      .osc_tick_i(osc_tick),
      .coarse_i(ctl_reg.coarse_trim_enable),
      .trim_i(trim_reg),
      .sec_tick_o(sec_tick_o),
      .sqw_1hz_o(hz1),
      .sqw_4khz_o(khz4),
      .sqw_8khz_o(khz8),
      .sqw_64hz_o(hz64)
   );

   // Pin mode: square wave beats alarm, alarm beats general purpose
   always_comb begin
      if (ctl_reg.square_wave_enable) begin
         mode = rtc_trim_backup_pkg::PIN_SQW;
      end else if (ctl_reg.alarm_zero_enable ||
                   ctl_reg.alarm_one_enable) begin
         mode = rtc_trim_backup_pkg::PIN_ALARM;
      end else begin
         mode = rtc_trim_backup_pkg::PIN_GPO;
      end
   end

   // Wanted wire level; 1 means released to the pull-up
   always_comb begin
      pin_level = 1'b1;
      case (mode)
         rtc_trim_backup_pkg::PIN_SQW: begin
            if (on_backup) begin
               pin_level = 1'b1;
            end else if (ctl_reg.coarse_trim_enable) begin
               pin_level = hz64;
            end else begin
               case (ctl_reg.clock_output_select)
                  2'h0: pin_level = hz1;
                  2'h1: pin_level = khz4;
                  2'h2: pin_level = khz8;
                  default: pin_level = osc_clk_i;
               endcase
            end
         end
         rtc_trim_backup_pkg::PIN_ALARM: begin
            // Disabled alarm is neutral in the OR and in the AND
            if (alarm_output_polarity_reg) begin
               pin_level = (alarm_zero_flag_i && ctl_reg.alarm_zero_enable)
                  || (alarm_one_flag_i && ctl_reg.alarm_one_enable);
            end else begin
               pin_level = !((alarm_zero_flag_i ||
                  !ctl_reg.alarm_zero_enable) && (alarm_one_flag_i ||
                  !ctl_reg.alarm_one_enable));
            end
         end
         rtc_trim_backup_pkg::PIN_GPO: begin
            pin_level = on_backup ? 1'b1 : gpo_level;
         end
         default: pin_level = 1'b1;
      endcase
   end

   // Open drain: only ever pulls low
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         pin_oe_reg <= 1'b0;
      end else begin
         pin_oe_reg <= !pin_level;
      end
   end

   assign multi_function_pin_oe_o = pin_oe_reg;
   assign multi_function_pin_o = 1'b0;

   chk_gpo_follows_out: assert property (
      @(posedge clk_i) disable iff (!resetn_i)
      (mode == rtc_trim_backup_pkg::PIN_GPO && !on_backup)
      |=> (pin_oe_reg == !$past(gpo_level)))
      else $error("pin does not follow general purpose level");

   chk_backup_release: assert property (
      @(posedge clk_i) disable iff (!resetn_i)
      (on_backup && mode != rtc_trim_backup_pkg::PIN_ALARM)
      |=> !pin_oe_reg)
      else $error("pin driven on backup outside alarm mode");

   chk_coarse_64hz: assert property (
      @(posedge clk_i) disable iff (!resetn_i)
      (ctl_reg.square_wave_enable && ctl_reg.coarse_trim_enable &&
       !on_backup) |=> (pin_oe_reg == !$past(hz64)))
      else $error("coarse trim pin is not the 64 Hz clock");

   chk_bus_refused: assert property (
      @(posedge clk_i) disable iff (!resetn_i)
      (rd_i && on_backup) |=> (rdata_o == 8'h00))
      else $error("read answered while on backup");

   chk_switchover: assert property (
      @(posedge clk_i) disable iff (!resetn_i)
      1'b1 |=> (on_backup_reg ==
         $past(vcc_low_i && backup_input_enable_reg)))
      else $error("supply switchover state wrong");

   chk_stamp_down: assert property (
      @(posedge clk_i) disable iff (!resetn_i)
      (down_evt && !power_loss_flag_reg)
      |=> (power_loss_flag_reg && pd_reg == $past(time_masked)))
      else $error("power-down stamp or flag not recorded");

   chk_flag_holds: assert property (
      @(posedge clk_i) disable iff (!resetn_i)
      (down_evt && power_loss_flag_reg) |=> $stable(pd_reg))
      else $error("down stamp overwritten while flag set");

   chk_clear_stamps: assert property (
      @(posedge clk_i) disable iff (!resetn_i)
      flag_clear_wr |=> (pd_reg == '0 && pu_reg ==
         ($past(up_evt && armed_reg) ? $past(time_masked) : '0)))
      else $error("stamps not cleared with the flag");

   chk_stamp_up: assert property (
      @(posedge clk_i) disable iff (!resetn_i)
      (up_evt && armed_reg) |=> (pu_reg == $past(time_masked)))
      else $error("power-up stamp not recorded");

   cov_outage: cover property (
      @(posedge clk_i) disable iff (!resetn_i)
      down_evt ##[1:1000] up_evt);

   cov_coarse_out: cover property (
      @(posedge clk_i) disable iff (!resetn_i)
      mode == rtc_trim_backup_pkg::PIN_SQW &&
      ctl_reg.coarse_trim_enable && pin_oe_reg);

   cov_dual_alarm: cover property (
      @(posedge clk_i) disable iff (!resetn_i)
      ctl_reg.alarm_zero_enable && ctl_reg.alarm_one_enable &&
      pin_oe_reg);

endmodule : rtc_trim_backup_output_ctrl

// ### rtc_pin_load.sv
// Pull-up load on the open-drain pin with a rise-to-rise period meter
`timescale 1ns/100ps

module rtc_pin_load (
   // Clock and reset
   input wire logic clk_i,
   input wire logic resetn_i,
   // Pin driver
   input wire logic pin_i,
   input wire logic pin_oe_i,
   // Observed level and period in clock cycles
   output logic level_o,
   output logic [15:0] period_o
);
   logic [15:0] cnt_reg;
   logic level_reg;

   // Released pin is pulled high, never left at its last value
   assign level_o = pin_oe_i ? pin_i : 1'b1;

   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         cnt_reg <= 16'h0000;
         level_reg <= 1'b1;
         period_o <= 16'h0000;
      end else begin
         level_reg <= level_o;
         if (level_o && !level_reg) begin
            period_o <= cnt_reg;
            cnt_reg <= 16'h0001;
         end else begin
            cnt_reg <= cnt_reg + 16'h0001;
         end
      end
   end
endmodule : rtc_pin_load

// ### tb_rtc_trim_backup_output_ctrl.sv
// Self-checking bench for trim, pin output and backup time-stamps
`timescale 1ns/100ps
`include "rtc_trim_backup_regs.svh"

module tb_rtc_trim_backup_output_ctrl;
   logic clk_i = 1'b0;
   logic resetn_i = 1'b0;
   logic [7:0] addr_i = 8'h00;
   logic [7:0] wdata_i = 8'h00;
   logic wr_i = 1'b0;
   logic rd_i = 1'b0;
   logic osc_clk_i = 1'b0;
   logic vcc_low_i = 1'b0;
   rtc_trim_backup_pkg::stamp_t time_now_i = '0;
   logic alarm_zero_flag_i = 1'b0;
   logic alarm_one_flag_i = 1'b0;
   logic [7:0] rdata_o;
   logic bus_refused_o, sec_tick_o, on_backup_o, ext_sel;
   logic multi_function_pin_o, multi_function_pin_oe_o, level;
   logic [15:0] period;
   logic [7:0] exp_q[$];
   logic pend = 1'b0;
   logic bk = 1'b0;
   logic [31:0] lfsr = 32'h05ED761E;
   int fail_count = 0;
   int total_checks = 0;
   int cycles = 0;
   int sec_cnt = 0;
   int sec_per = 0;

   rtc_trim_backup_output_ctrl rtc_trim_backup_output_ctrl_inst (
      .clk_i(clk_i), .resetn_i(resetn_i), .addr_i(addr_i),
      .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
      .bus_refused_o(bus_refused_o), .osc_clk_i(osc_clk_i),
      .vcc_low_i(vcc_low_i), .time_now_i(time_now_i),
      .alarm_zero_flag_i(alarm_zero_flag_i),
      .alarm_one_flag_i(alarm_one_flag_i), .sec_tick_o(sec_tick_o),
      .on_backup_o(on_backup_o), .external_clock_select_o(ext_sel),
      .multi_function_pin_o(multi_function_pin_o),
      .multi_function_pin_oe_o(multi_function_pin_oe_o));

   rtc_pin_load rtc_pin_load_inst (
      .clk_i(clk_i), .resetn_i(resetn_i), .pin_i(multi_function_pin_o),
      .pin_oe_i(multi_function_pin_oe_o), .level_o(level),
      .period_o(period));

   always #2.5 clk_i = ~clk_i;

   // Fastest legal oscillator keeps trimmed seconds short
   always @(posedge clk_i) osc_clk_i <= ~osc_clk_i;

   function automatic logic [31:0] step(input logic [31:0] v);
      return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
   endfunction : step

   task automatic stop_test;
      $display("checks %0d mismatches %0d", total_checks, fail_count);
      if (fail_count == 0 && total_checks > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask : stop_test

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         fail_count++;
         $display("BAD %0t got %h expected %h", $time, got, exp);
      end
   endtask : chk

   always @(posedge clk_i) begin
      cycles++;
      if (sec_tick_o === 1'b1) begin
         sec_per = sec_cnt;
         sec_cnt = 0;
      end
      sec_cnt++;
      if (cycles == 30000) begin
         fail_count++;
         stop_test();
      end
   end

   // Read data stands only in the cycle after the strobe
   always @(posedge clk_i) begin
      if (pend)
         chk(rdata_o, exp_q.pop_front());
      pend = rd_i;
   end

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk_i);
      wr_i <= 1'b1;
      addr_i <= a;
      wdata_i <= d;
      @(posedge clk_i);
      chk(bus_refused_o, bk);
      wr_i <= 1'b0;
   endtask : wr

   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      @(posedge clk_i);
      rd_i <= 1'b1;
      addr_i <= a;
      exp_q.push_back(bk ? 8'h00 : e);
      @(posedge clk_i);
      chk(bus_refused_o, bk);
      rd_i <= 1'b0;
   endtask : rd

   task automatic rd_stamp(input logic [7:0] base, input logic [31:0] s);
      for (int i = 0; i < 4; i++)
         rd(base + 8'(i), s[8*i +: 8]);
   endtask : rd_stamp

   task automatic pin(input logic e);
      repeat (3) @(posedge clk_i);
      chk(level, e);
   endtask : pin

   task automatic power(input logic low);
      @(posedge clk_i);
      vcc_low_i <= low;
      repeat (3) @(posedge clk_i);
   endtask : power

   task automatic new_time(output logic [31:0] t);
      lfsr = step(lfsr);
      time_now_i <= lfsr;
      t = lfsr & `STAMP_MASK;
   endtask : new_time

   // Half period of the 64 Hz output is one trimmed segment
   task automatic coarse(input logic [7:0] t);
      int seg;
      seg = t[7] ? 256 - 2 * t[6:0] : 256 + 2 * t[6:0];
      wr(`OSC_TRIM_ADDR, t);
      repeat (2600) @(posedge clk_i);
      chk(period, 4 * seg);
   endtask : coarse

   initial begin
      logic [31:0] t_dn, t_up, t_x;
      logic [7:0] r;
      int drv;
      repeat (2) @(posedge clk_i);
      resetn_i <= 1'b1;
      rd(`CONTROL_ADDR, `CONTROL_RESET);
      rd(`OSC_TRIM_ADDR, `OSC_TRIM_RESET);
      rd(`STATUS_ADDR, `STATUS_RESET);
      rd(8'h40, 8'h00);
      pin(1'b1);
      lfsr = step(lfsr);
      r = lfsr[7:0];
      wr(`OSC_TRIM_ADDR, r);
      rd(`OSC_TRIM_ADDR, r);
      wr(`CONTROL_ADDR, 8'h04);
      rd(`CONTROL_ADDR, 8'h04);
      wr(`CONTROL_ADDR, 8'h08);
      rd(`CONTROL_ADDR, 8'h08);
      chk(ext_sel, 1'b1);
      wr(`CONTROL_ADDR, 8'h00);
      pin(1'b0);
      chk(ext_sel, 1'b0);
      wr(`CONTROL_ADDR, 8'h80);
      pin(1'b1);
      for (int i = 0; i < 8; i++) begin
         wr(`ALARM_CFG_ADDR, {i[2], 7'h00});
         alarm_zero_flag_i <= i[0];
         alarm_one_flag_i <= i[1];
         wr(`CONTROL_ADDR, 8'h30);
         pin(i[2] ? (i[0] | i[1]) : !(i[0] & i[1]));
      end
      power(1'b1);
      chk(on_backup_o, 1'b0);
      rd(`CONTROL_ADDR, 8'h30);
      power(1'b0);
      wr(`STATUS_ADDR, 8'h08);
      wr(`CONTROL_ADDR, 8'h00);
      new_time(t_dn);
      power(1'b1);
      bk = 1'b1;
      chk(on_backup_o, 1'b1);
      pin(1'b1);
      wr(`OSC_TRIM_ADDR, 8'h33);
      rd(`CONTROL_ADDR, 8'h00);
      new_time(t_up);
      power(1'b0);
      bk = 1'b0;
      chk(on_backup_o, 1'b0);
      pin(1'b0);
      rd(`OSC_TRIM_ADDR, r);
      rd(`STATUS_ADDR, 8'h18);
      rd_stamp(`PD_STAMP_ADDR, t_dn);
      rd_stamp(`PU_STAMP_ADDR, t_up);
      new_time(t_x);
      power(1'b1);
      power(1'b0);
      rd_stamp(`PD_STAMP_ADDR, t_dn);
      rd_stamp(`PU_STAMP_ADDR, t_up);
      wr(`STATUS_ADDR, 8'h08);
      rd(`STATUS_ADDR, 8'h08);
      rd_stamp(`PD_STAMP_ADDR, 32'h00000000);
      rd_stamp(`PU_STAMP_ADDR, 32'h00000000);
      wr(`CONTROL_ADDR, 8'h44);
      coarse(8'h01);
      coarse(8'h81);
      coarse(8'h00);
      wr(`OSC_TRIM_ADDR, 8'hFF);
      power(1'b1);
      drv = 0;
      repeat (1600) begin
         @(posedge clk_i);
         if (multi_function_pin_oe_o !== 1'b0)
            drv++;
      end
      chk(drv, 0);
      chk(sec_per, 512);
      power(1'b0);
      wr(`CONTROL_ADDR, 8'h43);
      repeat (20) @(posedge clk_i);
      chk(period, 2);
      repeat (3) @(posedge clk_i);
      stop_test();
   end
endmodule : tb_rtc_trim_backup_output_ctrl
